// >>> hdl/alu_mul_unit.sv
// Logic, arithmetic and multiply execution unit with an Avalon-MM slave.
// Assumes a synchronous master on ref_clk_i honouring waitrequest.
`timescale 1ns/100ps
// Contract
// - One's complement writes all-ones minus the destination and updates Z, C and N.
// - Negate writes zero minus the destination and updates Z, C, N and V.
// - Set-bits ORs the destination with the source register mask, updates Z and N and clears V.
// - Clear-bits ANDs the destination with all-ones minus the mask, updates Z and N and clears V.
// - Increment adds one and updates Z, N and V but never carry.
// - Decrement subtracts one and updates Z, N and V but never carry.
// - Test leaves the destination unchanged, sets Z and N from it and clears V.
// - Clear-register writes zero and updates Z, N and V.
// - Set-register loads all-ones and leaves every flag alone.
// - Unsigned multiply puts the unsigned product in the result pair and updates Z and C.
// - Signed multiply puts the signed product in the result pair and updates Z and C.
// - Mixed multiply treats the first operand as signed and the second as unsigned.
// - Unsigned fractional multiply stores the product shifted left by one.
// - Signed and mixed fractional multiplies store the signed or mixed product shifted left by one.
module alu_mul_unit (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic rstn_i,
   // Avalon-MM slave
   input wire logic [4:0] address_i,
   input wire logic read_i,
   input wire logic write_i,
   input wire logic [31:0] writedata_i,
   output logic [31:0] readdata_o,
   output logic waitrequest_o
);
   // ==========================================================
   // Bus handshake
   logic accept;
   logic exec;
   logic [7:0] dest_reg;
   logic [7:0] source_reg;
   logic [7:0] res_lo_reg;
   logic [7:0] res_hi_reg;
   logic [3:0] flags_reg;
   logic [3:0] op_reg;

   assign accept = (read_i | write_i) & ~waitrequest_o;
   assign exec = write_i & ~waitrequest_o & (address_i == alu_mul_pkg::cmd_ofs);

   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         waitrequest_o <= 1'b1;
      end else if ((read_i | write_i) & waitrequest_o) begin
         waitrequest_o <= 1'b0;
      end else begin
         waitrequest_o <= 1'b1;
      end
   end

   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         readdata_o <= 32'h0000_0000;
      end else if (read_i & waitrequest_o) begin
         unique case (address_i)
            alu_mul_pkg::dest_ofs: readdata_o <= {24'h00_0000, dest_reg};
            alu_mul_pkg::source_ofs: readdata_o <= {24'h00_0000, source_reg};
            alu_mul_pkg::cmd_ofs: readdata_o <= {28'h000_0000, op_reg};
            alu_mul_pkg::res_lo_ofs: readdata_o <= {24'h00_0000, res_lo_reg};
            alu_mul_pkg::res_hi_ofs: readdata_o <= {24'h00_0000, res_hi_reg};
            alu_mul_pkg::flags_ofs: readdata_o <= {28'h000_0000, flags_reg};
            default: readdata_o <= 32'h0000_0000;
         endcase
      end
   end

   // ==========================================================
   // Datapath
   logic [7:0] res8_next;
   logic [15:0] prod_next;
   logic [3:0] flags_next;
   logic wr_dest;
   logic wr_pair;
   logic a_sgn;
   logic b_sgn;
   logic frac;
   logic signed [8:0] a_ext;
   logic signed [8:0] b_ext;
   logic signed [17:0] prod_full;
   logic [15:0] prod_raw;
   logic [3:0] op;

   assign op = writedata_i[3:0];
   assign a_sgn = (op == alu_mul_pkg::signed_multiply_op) || (op == alu_mul_pkg::mixed_multiply_op) ||
      (op == alu_mul_pkg::fractional_signed_multiply_op) || (op == alu_mul_pkg::fractional_mixed_multiply_op);
   assign b_sgn = (op == alu_mul_pkg::signed_multiply_op) ||
      (op == alu_mul_pkg::fractional_signed_multiply_op);
   assign a_ext = $signed({a_sgn & dest_reg[7], dest_reg});
   assign b_ext = $signed({b_sgn & source_reg[7], source_reg});
   assign prod_full = 18'(a_ext) * 18'(b_ext);
   assign prod_raw = prod_full[15:0];

   always_comb begin
      res8_next = dest_reg;
      prod_next = prod_raw;
      flags_next = flags_reg;
      wr_dest = 1'b0;
      wr_pair = 1'b0;
      frac = 1'b0;
      unique case (op)
         alu_mul_pkg::ones_complement_op: begin
            res8_next = alu_mul_pkg::all_ones - dest_reg;
            wr_dest = 1'b1;
            flags_next[alu_mul_pkg::flag_c_pos] = 1'b1;
         end
         alu_mul_pkg::negate_op: begin
            res8_next = alu_mul_pkg::byte_rst - dest_reg;
            wr_dest = 1'b1;
            flags_next[alu_mul_pkg::flag_c_pos] = (res8_next != alu_mul_pkg::byte_rst);
            flags_next[alu_mul_pkg::flag_v_pos] = (res8_next == alu_mul_pkg::min_neg);
         end
         alu_mul_pkg::set_bits_op: begin
            res8_next = dest_reg | source_reg;
            wr_dest = 1'b1;
            flags_next[alu_mul_pkg::flag_v_pos] = 1'b0;
         end
         alu_mul_pkg::clear_bits_op: begin
            res8_next = dest_reg & (alu_mul_pkg::all_ones - source_reg);
            wr_dest = 1'b1;
            flags_next[alu_mul_pkg::flag_v_pos] = 1'b0;
         end
         alu_mul_pkg::increment_op: begin
            res8_next = dest_reg + 8'h01;
            wr_dest = 1'b1;
            flags_next[alu_mul_pkg::flag_v_pos] = (dest_reg == alu_mul_pkg::max_pos);
         end
         alu_mul_pkg::decrement_op: begin
            res8_next = dest_reg - 8'h01;
            wr_dest = 1'b1;
            flags_next[alu_mul_pkg::flag_v_pos] = (dest_reg == alu_mul_pkg::min_neg);
         end
         alu_mul_pkg::test_zero_minus_op: begin
            res8_next = dest_reg & dest_reg;
            wr_dest = 1'b1;
            flags_next[alu_mul_pkg::flag_v_pos] = 1'b0;
         end
         alu_mul_pkg::clear_register_op: begin
            res8_next = dest_reg ^ dest_reg;
            wr_dest = 1'b1;
            flags_next[alu_mul_pkg::flag_v_pos] = 1'b0;
         end
         alu_mul_pkg::set_register_op: begin
            res8_next = alu_mul_pkg::all_ones;
            wr_dest = 1'b1;
         end
         alu_mul_pkg::unsigned_multiply_op: begin
            wr_pair = 1'b1;
         end
         alu_mul_pkg::signed_multiply_op: begin
            wr_pair = 1'b1;
         end
         alu_mul_pkg::mixed_multiply_op: begin
            wr_pair = 1'b1;
         end
         alu_mul_pkg::fractional_unsigned_multiply_op: begin
            frac = 1'b1;
            wr_pair = 1'b1;
         end
         alu_mul_pkg::fractional_signed_multiply_op: begin
            frac = 1'b1;
            wr_pair = 1'b1;
         end
         alu_mul_pkg::fractional_mixed_multiply_op: begin
            frac = 1'b1;
            wr_pair = 1'b1;
         end
         default: begin
            res8_next = dest_reg;
         end
      endcase
      if (frac) begin
         prod_next = {prod_raw[14:0], 1'b0};
      end
      if (wr_dest && op != alu_mul_pkg::set_register_op) begin
         flags_next[alu_mul_pkg::flag_z_pos] = (res8_next == alu_mul_pkg::byte_rst);
         flags_next[alu_mul_pkg::flag_n_pos] = res8_next[7];
      end
      if (wr_pair) begin
         flags_next[alu_mul_pkg::flag_c_pos] = prod_raw[15];
         flags_next[alu_mul_pkg::flag_z_pos] = (prod_next == 16'h0000);
      end
   end

   // ==========================================================
   // Registers
   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         dest_reg <= alu_mul_pkg::byte_rst;
      end else if (exec && wr_dest) begin
         dest_reg <= res8_next;
      end else if (accept && write_i && address_i == alu_mul_pkg::dest_ofs) begin
         dest_reg <= writedata_i[7:0];
      end
   end

   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         source_reg <= alu_mul_pkg::byte_rst;
      end else if (accept && write_i && address_i == alu_mul_pkg::source_ofs) begin
         source_reg <= writedata_i[7:0];
      end
   end

   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         op_reg <= 4'h0;
         res_lo_reg <= alu_mul_pkg::byte_rst;
         res_hi_reg <= alu_mul_pkg::byte_rst;
         flags_reg <= alu_mul_pkg::flags_rst;
      end else if (exec) begin
         op_reg <= op;
         flags_reg <= flags_next;
         if (wr_dest) begin
            res_lo_reg <= res8_next;
         end else if (wr_pair) begin
            res_lo_reg <= prod_next[7:0];
            res_hi_reg <= prod_next[15:8];
         end
      end else if (accept && write_i && address_i == alu_mul_pkg::flags_ofs) begin
         flags_reg <= writedata_i[3:0];
      end
   end

   // ==========================================================
   // Checks
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rstn_i);

   sequence s_exec(logic [3:0] code);
      exec && op == code;
   endsequence

   chk_invert_result: assert property (s_exec(alu_mul_pkg::ones_complement_op) |=>
      dest_reg == ~$past(dest_reg) && flags_reg[alu_mul_pkg::flag_c_pos]) else $error("complement wrong");
   chk_invert_ovf: assert property (s_exec(alu_mul_pkg::ones_complement_op) |=>
      $stable(flags_reg[alu_mul_pkg::flag_v_pos])) else $error("complement touched overflow");
   chk_neg_result: assert property (s_exec(alu_mul_pkg::negate_op) |=>
      dest_reg == 8'h00 - $past(dest_reg) && flags_reg[alu_mul_pkg::flag_c_pos] == (dest_reg != 8'h00))
      else $error("negate wrong");
   chk_setbits_result: assert property (s_exec(alu_mul_pkg::set_bits_op) |=>
      dest_reg == ($past(dest_reg) | source_reg)) else $error("set bits wrong");
   chk_setbits_carry: assert property (s_exec(alu_mul_pkg::set_bits_op) |=>
      $stable(flags_reg[alu_mul_pkg::flag_c_pos])) else $error("set bits touched carry");
   chk_clearbits_result: assert property (s_exec(alu_mul_pkg::clear_bits_op) |=>
      (dest_reg & source_reg) == 8'h00 && dest_reg == ($past(dest_reg) & ~source_reg))
      else $error("clear bits wrong");
   chk_inc_carry: assert property (s_exec(alu_mul_pkg::increment_op) |=>
      dest_reg == $past(dest_reg) + 8'h01 && $stable(flags_reg[alu_mul_pkg::flag_c_pos]))
      else $error("increment wrong");
   chk_inc_ovf: assert property (s_exec(alu_mul_pkg::increment_op) |=>
      flags_reg[alu_mul_pkg::flag_v_pos] == ($past(dest_reg) == alu_mul_pkg::max_pos)) else $error("increment overflow");
   chk_dec_carry: assert property (s_exec(alu_mul_pkg::decrement_op) |=>
      dest_reg == $past(dest_reg) - 8'h01 && $stable(flags_reg[alu_mul_pkg::flag_c_pos]))
      else $error("decrement wrong");
   chk_dec_ovf: assert property (s_exec(alu_mul_pkg::decrement_op) |=>
      flags_reg[alu_mul_pkg::flag_v_pos] == ($past(dest_reg) == alu_mul_pkg::min_neg)) else $error("decrement overflow");
   chk_test_keep: assert property (s_exec(alu_mul_pkg::test_zero_minus_op) |=>
      $stable(dest_reg) && !flags_reg[alu_mul_pkg::flag_v_pos]) else $error("test changed value");
   chk_clr_zero: assert property (s_exec(alu_mul_pkg::clear_register_op) |=>
      dest_reg == 8'h00 && flags_reg[alu_mul_pkg::flag_z_pos]) else $error("clear wrong");
   chk_setreg_flags: assert property (s_exec(alu_mul_pkg::set_register_op) |=>
      dest_reg == 8'hff && $stable(flags_reg)) else $error("set register touched flags");
   chk_mul_product: assert property (s_exec(alu_mul_pkg::unsigned_multiply_op) |=>
      {res_hi_reg, res_lo_reg} == 16'($past(dest_reg)) * 16'($past(source_reg))) else $error("multiply wrong");
   chk_signed_product: assert property (s_exec(alu_mul_pkg::signed_multiply_op) |=>
      {res_hi_reg, res_lo_reg} == 16'($signed($past(dest_reg))) * 16'($signed($past(source_reg))))
      else $error("signed multiply wrong");
   chk_mixed_product: assert property (s_exec(alu_mul_pkg::mixed_multiply_op) |=>
      {res_hi_reg, res_lo_reg} == 16'($signed($past(dest_reg))) * 16'($past(source_reg)))
      else $error("mixed multiply wrong");
   chk_frac_shift: assert property (s_exec(alu_mul_pkg::fractional_unsigned_multiply_op) |=>
      !res_lo_reg[0] && {res_hi_reg, res_lo_reg} == (16'($past(dest_reg)) * 16'($past(source_reg))) << 1)
      else $error("fraction not shifted");
   chk_frac_signed: assert property (s_exec(alu_mul_pkg::fractional_signed_multiply_op) |=>
      {res_hi_reg, res_lo_reg} == (16'($signed($past(dest_reg))) * 16'($signed($past(source_reg)))) << 1)
      else $error("signed fraction wrong");
   chk_pair_zero: assert property (exec && wr_pair |=>
      flags_reg[alu_mul_pkg::flag_z_pos] == ({res_hi_reg, res_lo_reg} == 16'h0000))
      else $error("product zero flag wrong");
   chk_nop_keep: assert property (s_exec(4'h0) |=>
      $stable(flags_reg) && $stable(dest_reg)) else $error("idle code changed state");
   chk_wait_one: assert property ((read_i || write_i) && waitrequest_o |=> !waitrequest_o)
      else $error("wait longer than one cycle");
endmodule : alu_mul_unit

// >>> hdl/alu_mul_pkg.sv
// Constants for the logic, arithmetic and multiply execution unit.
// Assumes a single 25 MHz core clock and an Avalon-MM register port.
package alu_mul_pkg;
   // ==========================================================
   // Register byte offsets
   localparam logic [4:0] dest_ofs = 5'h00;
   localparam logic [4:0] source_ofs = 5'h04;
   localparam logic [4:0] cmd_ofs = 5'h08;
   localparam logic [4:0] res_lo_ofs = 5'h0c;
   localparam logic [4:0] res_hi_ofs = 5'h10;
   localparam logic [4:0] flags_ofs = 5'h14;
   // ==========================================================
   // Flag bit positions in the flags register
   localparam int flag_c_pos = 0;
   localparam int flag_z_pos = 1;
   localparam int flag_n_pos = 2;
   localparam int flag_v_pos = 3;
   // ==========================================================
   // Reset values and byte constants
   localparam logic [7:0] byte_rst = 8'h00;
   localparam logic [3:0] flags_rst = 4'h0;
   localparam logic [7:0] all_ones = 8'hff;
   localparam logic [7:0] min_neg = 8'h80;
   localparam logic [7:0] max_pos = 8'h7f;
   // ==========================================================
   // Operation codes written to the command register
   localparam logic [3:0] ones_complement_op = 4'h1;
   localparam logic [3:0] negate_op = 4'h2;
   localparam logic [3:0] set_bits_op = 4'h3;
   localparam logic [3:0] clear_bits_op = 4'h4;
   localparam logic [3:0] increment_op = 4'h5;
   localparam logic [3:0] decrement_op = 4'h6;
   localparam logic [3:0] test_zero_minus_op = 4'h7;
   localparam logic [3:0] clear_register_op = 4'h8;
   localparam logic [3:0] set_register_op = 4'h9;
   localparam logic [3:0] unsigned_multiply_op = 4'ha;
   localparam logic [3:0] signed_multiply_op = 4'hb;
   localparam logic [3:0] mixed_multiply_op = 4'hc;
   localparam logic [3:0] fractional_unsigned_multiply_op = 4'hd;
   localparam logic [3:0] fractional_signed_multiply_op = 4'he;
   localparam logic [3:0] fractional_mixed_multiply_op = 4'hf;
endpackage : alu_mul_pkg

// >>> testbench/avalon_master_model.sv
// Avalon-MM master standing in for the decoder and register file.
// Assumes a slave that lowers waitrequest once per access.
`timescale 1ns/100ps
module avalon_master_model (
   // Clock
   input wire logic ref_clk_i,
   // Avalon-MM master side
   output logic [4:0] address_o,
   output logic read_o,
   output logic write_o,
   output logic [31:0] writedata_o,
   input wire logic waitrequest_i
);
   // ==========
   // Idle levels
   initial begin
      address_o = 5'h00;
      read_o = 1'b0;
      write_o = 1'b0;
      writedata_o = 32'h0;
   end
   // ==========
   // One access, held until waitrequest low
   task automatic access(input logic rd, input logic [4:0] a, input logic [31:0] d, input int gap,
                         output bit ok);
      int n;
      repeat (gap) @(posedge ref_clk_i);
      @(posedge ref_clk_i);
      address_o <= a;
      writedata_o <= d;
      read_o <= rd;
      write_o <= !rd;
      ok = 1'b0;
      for (n = 0; n < 64 && !ok; n++) begin
         @(posedge ref_clk_i);
         ok = (waitrequest_i === 1'b0);
      end
      read_o <= 1'b0;
      write_o <= 1'b0;
      writedata_o <= ~d;
   endtask : access
endmodule : avalon_master_model

// >>> testbench/logic_arith_multiply_unit_tb.sv
// Self-checking bench for the execution unit.
// Assumes one wait cycle per access and the register map of the package.
`timescale 1ns/100ps
module logic_arith_multiply_unit_tb;
   logic ref_clk_i = 1'b0;
   logic rstn_i = 1'b0;
   logic [4:0] address;
   logic read;
   logic write;
   logic [31:0] writedata;
   logic [31:0] readdata;
   logic waitrequest;
   logic [31:0] exp_q[$];
   int error_cnt = 0;
   int samples_checked = 0;
   logic [31:0] seed = 32'h0000_cb10;
   logic [7:0] m_dest, m_src, m_lo, m_hi;
   logic [3:0] m_fl, m_cmd;
   logic [7:0] edge_vals [4] = '{8'h00, 8'h7f, 8'h80, 8'hff};
   always #20 ref_clk_i = ~ref_clk_i;
   alu_mul_unit dut_u (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .address_i(address), .read_i(read),
      .write_i(write), .writedata_i(writedata), .readdata_o(readdata), .waitrequest_o(waitrequest));
   avalon_master_model mst_u (.ref_clk_i(ref_clk_i), .address_o(address), .read_o(read), .write_o(write),
      .writedata_o(writedata), .waitrequest_i(waitrequest));
   // ==========
   // Helpers
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xs
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      samples_checked++;
      if (seen !== want) begin
         error_cnt++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask : check
   task automatic give_verdict();
      $display("compares %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : give_verdict
   task automatic acc(input logic rd, input logic [4:0] a, input logic [31:0] d);
      bit ok;
      mst_u.access(rd, a, d, int'(xs() % 3), ok);
      if (!ok) begin
         error_cnt++;
         give_verdict();
      end
   endtask : acc
   task automatic rd_exp(input logic [4:0] a, input logic [7:0] want);
      exp_q.push_back({24'h0, want});
      acc(1'b1, a, 32'h0);
   endtask : rd_exp
   task automatic read_all();
      rd_exp(alu_mul_pkg::dest_ofs, m_dest);
      rd_exp(alu_mul_pkg::source_ofs, m_src);
      rd_exp(alu_mul_pkg::res_lo_ofs, m_lo);
      rd_exp(alu_mul_pkg::res_hi_ofs, m_hi);
      rd_exp(alu_mul_pkg::flags_ofs, {4'h0, m_fl});
      rd_exp(alu_mul_pkg::cmd_ofs, {4'h0, m_cmd});
      rd_exp(5'h18, 8'h00);
   endtask : read_all
   task automatic do_reset();
      @(posedge ref_clk_i);
      rstn_i <= 1'b0;
      repeat (3) @(posedge ref_clk_i);
      rstn_i <= 1'b1;
      {m_dest, m_src, m_lo, m_hi, m_fl, m_cmd} = '0;
      read_all();
   endtask : do_reset
   // ==========
   // Reference model
   task automatic model(input logic [3:0] op);
      logic [7:0] r;
      logic [15:0] p;
      int a;
      int b;
      r = m_dest;
      a = m_dest;
      b = m_src;
      case (op)
         alu_mul_pkg::ones_complement_op: r = 8'hff - m_dest;
         alu_mul_pkg::negate_op: r = 8'h00 - m_dest;
         alu_mul_pkg::set_bits_op: r = m_dest | m_src;
         alu_mul_pkg::clear_bits_op: r = m_dest & (8'hff - m_src);
         alu_mul_pkg::increment_op: r = m_dest + 8'h01;
         alu_mul_pkg::decrement_op: r = m_dest - 8'h01;
         alu_mul_pkg::clear_register_op: r = 8'h00;
         alu_mul_pkg::set_register_op: r = 8'hff;
         default: r = m_dest;
      endcase
      if (op >= 4'h1 && op <= 4'h8) begin
         m_fl[1] = (r == 8'h00);
         m_fl[2] = r[7];
         if (op != alu_mul_pkg::ones_complement_op) m_fl[3] = (op == alu_mul_pkg::increment_op) ?
            (m_dest == 8'h7f) : (op == alu_mul_pkg::decrement_op) ? (m_dest == 8'h80) :
            (op == alu_mul_pkg::negate_op) ? (r == 8'h80) : 1'b0;
         if (op <= 4'h2) m_fl[0] = (op == alu_mul_pkg::ones_complement_op) | (r != 8'h00);
      end
      if (op >= 4'h1 && op <= 4'h9) begin
         m_dest = r;
         m_lo = r;
      end
      if (op >= 4'ha) begin
         if (op != 4'ha && op != 4'hd) a = $signed(m_dest);
         if (op == 4'hb || op == 4'he) b = $signed(m_src);
         p = 16'(a * b);
         m_fl[0] = p[15];
         if (op >= 4'hd) p = p << 1;
         m_fl[1] = (p == 16'h0000);
         {m_hi, m_lo} = p;
      end
   endtask : model
   // ==========
   // Monitor
   always @(posedge ref_clk_i) begin
      if (read === 1'b1 && waitrequest === 1'b0) begin
         check(readdata, exp_q.pop_front());
      end
   end
   // ==========
   // Main sequence
   initial begin
      int i;
      int k;
      logic [3:0] op;
      repeat (3) @(posedge ref_clk_i);
      rstn_i <= 1'b1;
      {m_dest, m_src, m_lo, m_hi, m_fl, m_cmd} = '0;
      read_all();
      acc(1'b0, 5'h18, 32'h5a);
      read_all();
      for (i = 0; i < 16 * 6; i++) begin
         op = 4'(i / 6);
         k = i % 6;
         m_dest = (k < 4) ? edge_vals[k] : 8'(xs());
         m_src = (k < 4) ? m_dest : 8'(xs());
         m_fl = 4'(xs());
         acc(1'b0, alu_mul_pkg::dest_ofs, {24'h0, m_dest});
         acc(1'b0, alu_mul_pkg::source_ofs, {24'h0, m_src});
         acc(1'b0, alu_mul_pkg::flags_ofs, {28'h0, m_fl});
         acc(1'b0, alu_mul_pkg::cmd_ofs, {28'h0, op});
         model(op);
         m_cmd = op;
         read_all();
         if (i == 50) do_reset();
      end
      repeat (2) @(posedge ref_clk_i);
      check(32'(exp_q.size()), 32'h0);
      give_verdict();
   end
endmodule : logic_arith_multiply_unit_tb
